//--- bench/aeq_conv_model.sv
// Converter-side sample source and sink model
`timescale 1ns/10ps
`default_nettype none
module aeq_conv_model (
	input  wire logic        pclk,
	input  wire logic        stall,
	input  wire logic        rec_in_ready,
	input  wire logic        play_in_ready,
	output logic             rec_in_valid,
	output logic [31:0]      rec_in_data,
	output logic             play_in_valid,
	output logic [31:0]      play_in_data,
	input  wire logic        out_valid,
	output logic             out_ready,
	input  wire logic [31:0] out_data,
	input  wire logic        out_to_play
);
	logic [32:0] txq[$];
	logic [32:0] got[$];
	initial
	begin
		rec_in_valid = 1'b0;
		play_in_valid = 1'b0;
		rec_in_data = 32'h0000_0000;
		play_in_data = 32'h0000_0000;
		out_ready = 1'b0;
	end
	// Head held until taken; idle lines toggle so stale data never looks valid
	always @(posedge pclk)
	begin : p_drive
		logic [32:0] h;
		logic        has;
		if ((rec_in_valid && rec_in_ready) || (play_in_valid && play_in_ready))
			txq.delete(0);
		has = txq.size() != 0;
		h = has ? txq[0] : 33'h0_0000_0000;
		rec_in_valid <= has && !h[32];
		play_in_valid <= has && h[32];
		rec_in_data <= (has && !h[32]) ? h[31:0] : ~rec_in_data;
		play_in_data <= (has && h[32]) ? h[31:0] : ~play_in_data;
		if (out_valid === 1'b1 && out_ready)
			got.push_back({out_to_play, out_data});
		out_ready <= !stall;
	end
endmodule : aeq_conv_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the audio filter chain
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [31:0] X0 = 32'hf830_03e8;
	logic        pclk = 1'b0, presetn = 1'b0, stall = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rec_in_data, play_in_data, out_data, q;
	logic        pready, pslverr, rec_in_valid, rec_in_ready, e;
	logic        play_in_valid, play_in_ready, out_valid, out_ready, out_to_play;
	logic [31:0] gtab [4] = '{X0, 32'he0c0_0fa0, 32'h8300_3e80, 32'h8300_3e80};
	int          err_total = 0, n_tests = 0, cyc = 0;
	always #10 pclk = ~pclk;
	aeq_chain #(.FIFO_DEPTH(aeq_pkg::FIFO_DEPTH)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rec_in_valid(rec_in_valid),
		.rec_in_ready(rec_in_ready), .rec_in_data(rec_in_data), .play_in_valid(play_in_valid),
		.play_in_ready(play_in_ready), .play_in_data(play_in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_to_play(out_to_play));
	aeq_conv_model u_conv (.pclk(pclk), .stall(stall), .rec_in_ready(rec_in_ready),
		.play_in_ready(play_in_ready), .rec_in_valid(rec_in_valid), .rec_in_data(rec_in_data),
		.play_in_valid(play_in_valid), .play_in_data(play_in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_to_play(out_to_play));
	task stop_test;
		$display("counts: %0d checks, %0d mismatches", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task check(input logic [32:0] v, input logic [32:0] x);
		n_tests++;
		if (v !== x)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, v, x);
		end
	endtask : check
	// One transfer; zero-wait slave, but the wait loop keeps us honest
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		check({e, q}, {1'b0, x});
	endtask : rd
	task wait_got(input int n);
		for (int i = 0; i < 400 && u_conv.got.size() < n; i++)
			@(posedge pclk);
		check(33'(u_conv.got.size()), 33'(n));
	endtask : wait_got
	// Power-off first so each run starts from empty history
	task pair(input logic pl, input logic [31:0] c, input logic [31:0] e0,
		input logic [31:0] e1);
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(aeq_pkg::ADDR_CTRL, c);
		u_conv.got.delete();
		u_conv.txq.push_back({pl, X0});
		u_conv.txq.push_back({pl, X0});
		wait_got(2);
		check(u_conv.got[0], {pl, e0});
		check(u_conv.got[1], {pl, e1});
	endtask : pair
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_total++;
			stop_test();
		end
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(33'({play_in_ready, rec_in_ready}), 33'h0_0000_0000);
		rd(aeq_pkg::ADDR_CTRL, 32'h0000_0000);
		rd(aeq_pkg::ADDR_WIND, 32'h0000_0000);
		rd(aeq_pkg::ADDR_STAT, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		check({e, q}, 33'h1_0000_0000);
		wr(aeq_pkg::ADDR_STAT, 32'hffff_ffff);
		rd(aeq_pkg::ADDR_STAT, 32'h0000_0000);
		wr(aeq_pkg::ADDR_EMPH, 32'hffff_ffff);
		rd(aeq_pkg::ADDR_EMPH, 32'h3fff_3fff);
		$display("test registers done");
		for (int g = 0; g < 4; g++)
			pair(1'b0, 32'h0000_0011 | (32'(g) << 9), gtab[g], gtab[g]);
		pair(1'b0, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000);
		$display("test gain and mute done");
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(aeq_pkg::ADDR_EQAC, 32'h1000_2000);
		wr(aeq_pkg::ADDR_EQB, 32'h0000_0000);
		wr(aeq_pkg::ADDR_EMPH, 32'h0000_1000);
		pair(1'b0, 32'h0000_0013, 32'hfc18_01f4, 32'h0000_0000);
		pair(1'b0, 32'h0000_0113, 32'hfc18_01f4, X0);
		pair(1'b0, 32'h0000_0031, X0, 32'hf448_05dc);
		pair(1'b0, 32'h0000_0231, 32'he0c0_0fa0, 32'hd120_1770);
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0000);
		wr(aeq_pkg::ADDR_WIND, 32'h3000_1000);
		rd(aeq_pkg::ADDR_WIND, 32'h3000_1000);
		pair(1'b0, 32'h0000_0051, 32'hfc18_01f4, 32'hfe0c_00fa);
		pair(1'b0, 32'h0000_00d1, 32'hfc18_01f4, 32'hf63c_04e2);
		pair(1'b0, 32'h0000_00d1, 32'hfc18_01f4, 32'hf63c_04e2);
		$display("test filters done");
		pair(1'b1, 32'h0000_0054, 32'hfc18_01f4, 32'hfe0c_00fa);
		rd(aeq_pkg::ADDR_STAT, 32'h0000_0002);
		check(33'(rec_in_ready), 33'h0_0000_0000);
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0007);
		rd(aeq_pkg::ADDR_STAT, 32'h0000_0001);
		rd(aeq_pkg::ADDR_WIND, 32'h3000_1000);
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0004);
		$display("test paths done");
		wr(aeq_pkg::ADDR_CTRL, 32'h0000_0011);
		stall <= 1'b1;
		u_conv.got.delete();
		for (int i = 0; i < 24; i++)
			u_conv.txq.push_back(33'(i));
		for (int i = 0; i < 100 && rec_in_ready !== 1'b0; i++)
			@(posedge pclk);
		rd(aeq_pkg::ADDR_STAT, 32'h0000_1001);
		stall <= 1'b0;
		wait_got(24);
		for (int i = 0; i < 24; i++)
			check(u_conv.got[i], 33'(i));
		rd(aeq_pkg::ADDR_STAT, 32'h0000_0001);
		$display("test buffer done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire

//--- hdl/aeq_chain.sv
// Stereo first-order IIR filter chain with APB control registers
`timescale 1ns/10ps
`default_nettype none
module aeq_chain #(
	parameter int FIFO_DEPTH = aeq_pkg::FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rec_in_valid,
	output logic             rec_in_ready,
	input  wire logic [31:0] rec_in_data,
	input  wire logic        play_in_valid,
	output logic             play_in_ready,
	input  wire logic [31:0] play_in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [31:0]      out_data,
	output logic             out_to_play
);
	logic [10:0]  ctrl_ff;
	logic [31:0]  wind_ff;
	logic [31:0]  emph_ff;
	logic [31:0]  eqac_ff;
	logic [13:0]  eqb_ff;
	logic [31:0]  prdata_ff;
	logic [31:0]  out_data_ff;
	logic         out_valid_ff;
	logic         out_play_ff;
	logic         rec_path;
	logic         play_path;
	logic         chain_on;
	logic         stereo;
	logic         src_valid;
	logic [31:0]  src_data;
	logic         src_ready;
	logic         f_valid;
	logic         f_ready;
	logic [31:0]  f_data;
	logic [$clog2(FIFO_DEPTH):0] f_level;
	logic         fire;
	logic [31:0]  chain_y;
	logic         wr_en;
	logic         hit;

	function automatic logic signed [15:0] aeq_sat(input logic signed [35:0] v);
		if (v > aeq_pkg::SAT_MAX)
			return 16'sh7fff;
		if (v < aeq_pkg::SAT_MIN)
			return 16'sh8000;
		return v[15:0];
	endfunction : aeq_sat

	// One first-order section, high-pass or low-pass
	function automatic logic signed [15:0] aeq_fo(
		input logic signed [15:0] x,
		input logic signed [15:0] x1,
		input logic signed [15:0] y1,
		input logic [13:0]        a,
		input logic [13:0]        b,
		input logic               lp
	);
		logic signed [35:0] n;
		logic signed [35:0] acc;
		n = lp ? 36'(x) + 36'(x1) : 36'(x) - 36'(x1);
		acc = 36'($signed(a)) * n - 36'($signed(b)) * 36'(y1);
		return aeq_sat(acc >>> aeq_pkg::FRAC);
	endfunction : aeq_fo

	function automatic logic in_map(input logic [7:0] a);
		return a == aeq_pkg::ADDR_CTRL || a == aeq_pkg::ADDR_WIND ||
			a == aeq_pkg::ADDR_EMPH || a == aeq_pkg::ADDR_EQAC ||
			a == aeq_pkg::ADDR_EQB || a == aeq_pkg::ADDR_STAT;
	endfunction : in_map

	assign rec_path  = ctrl_ff[aeq_pkg::B_LREC] || ctrl_ff[aeq_pkg::B_RREC];
	assign play_path = !rec_path && ctrl_ff[aeq_pkg::B_PLAY];
	assign chain_on  = rec_path || play_path;
	assign stereo    = ctrl_ff[aeq_pkg::B_LREC] && ctrl_ff[aeq_pkg::B_RREC];

	// APB slave, zero wait states
	assign hit     = in_map(paddr);
	assign wr_en   = psel && penable && pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= aeq_pkg::CTRL_RST;
			wind_ff <= aeq_pkg::COEF_RST;
			emph_ff <= aeq_pkg::COEF_RST;
			eqac_ff <= aeq_pkg::COEF_RST;
			eqb_ff  <= '0;
		end
		else if (wr_en)
		begin
			// Coefficients change only on writes, never on path moves
			unique case (paddr)
				aeq_pkg::ADDR_CTRL: ctrl_ff <= pwdata[10:0];
				aeq_pkg::ADDR_WIND: wind_ff <= pwdata & 32'h3fff_3fff;
				aeq_pkg::ADDR_EMPH: emph_ff <= pwdata & 32'h3fff_3fff;
				aeq_pkg::ADDR_EQAC: eqac_ff <= pwdata;
				aeq_pkg::ADDR_EQB: eqb_ff <= pwdata[13:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= '0;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				aeq_pkg::ADDR_CTRL: prdata_ff <= {21'h0, ctrl_ff};
				aeq_pkg::ADDR_WIND: prdata_ff <= wind_ff;
				aeq_pkg::ADDR_EMPH: prdata_ff <= emph_ff;
				aeq_pkg::ADDR_EQAC: prdata_ff <= eqac_ff;
				aeq_pkg::ADDR_EQB: prdata_ff <= {18'h0, eqb_ff};
				aeq_pkg::ADDR_STAT: prdata_ff <= {16'h0, 8'(f_level), 6'h0, play_path, rec_path};
				default: prdata_ff <= '0;
			endcase
		end
	end

	// Source select; the unused source sees no ready
	assign src_valid     = rec_path ? rec_in_valid : (play_path && play_in_valid);
	assign src_data      = rec_path ? rec_in_data : play_in_data;
	assign rec_in_ready  = rec_path && src_ready;
	assign play_in_ready = play_path && src_ready;

	aeq_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.flush     (!chain_on),
		.in_valid  (src_valid),
		.in_ready  (src_ready),
		.in_data   (src_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data),
		.level     (f_level)
	);

	// Output stall reaches back into the FIFO
	assign f_ready = chain_on && (!out_valid_ff || out_ready);
	assign fire    = f_valid && f_ready;

	generate
		for (genvar ch = 0; ch < 2; ch++)
		begin : g_ch
			logic signed [15:0] x1_ff [3];
			logic signed [15:0] y1_ff [3];
			logic signed [15:0] x0;
			logic signed [15:0] e_raw;
			logic signed [15:0] e_y;
			logic signed [15:0] q_raw;
			logic signed [15:0] q_y;
			logic signed [15:0] w_raw;
			logic signed [15:0] w_y;
			logic signed [15:0] g_y;
			logic signed [35:0] q_acc;

			// Empty FIFO shows stale or unknown words
			assign x0 = f_valid ? f_data[ch*16 +: 16] : 16'sh0000;

			always_comb
			begin
				e_raw = aeq_fo(x0, x1_ff[0], y1_ff[0], emph_ff[aeq_pkg::CW-1:0],
					emph_ff[aeq_pkg::COEF_B_POS +: aeq_pkg::CW],
					ctrl_ff[aeq_pkg::B_EMPH_TYPE]);
				if (!ctrl_ff[aeq_pkg::B_EMPH_EN])
					e_y = '0;
				else if (!stereo)
					e_y = x0;
				else
					e_y = e_raw;
				q_acc = 36'($signed(eqac_ff[aeq_pkg::EW-1:0])) * 36'(e_y)
					+ 36'($signed(eqac_ff[aeq_pkg::COEF_B_POS +: aeq_pkg::EW])) * 36'(x1_ff[1])
					- 36'($signed(eqb_ff)) * 36'(y1_ff[1]);
				q_raw = aeq_sat(q_acc >>> aeq_pkg::FRAC);
				q_y = ctrl_ff[aeq_pkg::B_EQ_EN] ? q_raw : e_y;
				w_raw = aeq_fo(q_y, x1_ff[2], y1_ff[2], wind_ff[aeq_pkg::CW-1:0],
					wind_ff[aeq_pkg::COEF_B_POS +: aeq_pkg::CW],
					ctrl_ff[aeq_pkg::B_WIND_TYPE]);
				w_y = ctrl_ff[aeq_pkg::B_WIND_EN] ? w_raw : q_y;
				unique case (ctrl_ff[aeq_pkg::B_GAIN+1 -: 2])
					2'b00: g_y = w_y;
					2'b01: g_y = aeq_sat(36'(w_y) <<< aeq_pkg::GAIN12_SH);
					default: g_y = aeq_sat(36'(w_y) <<< aeq_pkg::GAIN24_SH);
				endcase
			end

			assign chain_y[ch*16 +: 16] = g_y;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					x1_ff <= '{default: '0};
					y1_ff <= '{default: '0};
				end
				else if (!chain_on)
				begin
					x1_ff <= '{default: '0};
					y1_ff <= '{default: '0};
				end
				else if (fire)
				begin
					x1_ff[0] <= x0;
					y1_ff[0] <= e_raw;
					x1_ff[1] <= e_y;
					y1_ff[1] <= q_raw;
					x1_ff[2] <= q_y;
					y1_ff[2] <= w_raw;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_valid_ff <= 1'b0;
			out_data_ff  <= '0;
			out_play_ff  <= 1'b0;
		end
		else if (!chain_on)
			out_valid_ff <= 1'b0;
		else if (fire)
		begin
			out_valid_ff <= 1'b1;
			out_data_ff  <= chain_y;
			out_play_ff  <= play_path;
		end
		else if (out_ready)
			out_valid_ff <= 1'b0;
	end

	assign out_valid   = out_valid_ff;
	assign out_data    = out_data_ff;
	assign out_to_play = out_play_ff;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_fire;
		fire;
	endsequence

	sequence s_off;
		!chain_on;
	endsequence

	a_play_route: assert property (ctrl_ff[aeq_pkg::B_PLAY] && !rec_path
		|-> play_path && !rec_in_ready && play_in_ready == src_ready)
		else $error("playback route missing");
	a_rec_route: assert property (rec_path
		|-> !play_path && !play_in_ready && rec_in_ready == src_ready)
		else $error("record route wrong");
	a_coef_hold: assert property ($changed(rec_path) && !wr_en |-> $stable(wind_ff)
		&& $stable(emph_ff) && $stable(eqac_ff))
		else $error("coefficients moved with path");
	a_emph_mute: assert property (!ctrl_ff[aeq_pkg::B_EMPH_EN]
		|-> g_ch[0].e_y == 16'sh0000)
		else $error("emphasis not muted");
	a_emph_mono: assert property (ctrl_ff[aeq_pkg::B_EMPH_EN] && !stereo
		|-> g_ch[1].e_y == g_ch[1].x0)
		else $error("emphasis active in mono");
	a_wind_bypass: assert property (!ctrl_ff[aeq_pkg::B_WIND_EN]
		|-> g_ch[0].w_y == g_ch[0].q_y)
		else $error("wind stage not bypassed");
	a_gain_off: assert property (ctrl_ff[aeq_pkg::B_GAIN+1 -: 2] == 2'b00
		|-> g_ch[0].g_y == g_ch[0].w_y)
		else $error("unity gain violated");
	a_sample_out: assert property (s_fire
		|=> out_valid && out_data == $past(chain_y))
		else $error("sample not presented next cycle");
	a_state_clear: assert property (s_off ##1 s_off |-> g_ch[0].y1_ff[2] == 16'sh0000
		&& g_ch[1].x1_ff[0] == 16'sh0000)
		else $error("delay state kept while off");
	a_hp_history: assert property (s_fire ##1 !fire && chain_on
		|-> g_ch[0].x1_ff[0] == $past(g_ch[0].x0, 1))
		else $error("history not updated");
endmodule : aeq_chain
`default_nettype wire

//--- hdl/aeq_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module aeq_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ff];
	assign level     = cnt_ff;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ff] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else if (flush)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			if (pop)
				rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule : aeq_fifo
`default_nettype wire

//--- hdl/aeq_pkg.sv
// Constants shared by the audio filter chain
`default_nettype none
package aeq_pkg;
	localparam int SW = 16;
	localparam int FRAC = 13;
	localparam int CW = 14;
	localparam int EW = 16;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WIND = 8'h04;
	localparam logic [7:0] ADDR_EMPH = 8'h08;
	localparam logic [7:0] ADDR_EQAC = 8'h0c;
	localparam logic [7:0] ADDR_EQB = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	localparam int B_LREC = 0;
	localparam int B_RREC = 1;
	localparam int B_PLAY = 2;
	localparam int B_EMPH_EN = 4;
	localparam int B_EQ_EN = 5;
	localparam int B_WIND_EN = 6;
	localparam int B_WIND_TYPE = 7;
	localparam int B_EMPH_TYPE = 8;
	localparam int B_GAIN = 9;
	localparam int COEF_B_POS = 16;
	localparam logic [10:0] CTRL_RST = 11'h000;
	localparam logic [31:0] COEF_RST = 32'h0000_0000;
	localparam int GAIN12_SH = 2;
	localparam int GAIN24_SH = 4;
	localparam logic signed [35:0] SAT_MAX = 36'sh0_0000_7fff;
	localparam logic signed [35:0] SAT_MIN = 36'shf_ffff_8000;
endpackage : aeq_pkg
`default_nettype wire
